// ### mfd_pkg.sv
/*
 * constants, encodings and carrier structs for the mmu fault domain checker.
 * assumes one core clock domain; shared by the checker, the bus model and the bench.
 */
`default_nettype none
package mfd_pkg;
    // ----------------------------------------
    // coprocessor register selects
    // ----------------------------------------
    localparam logic [1:0] MFD_SEL_DFSR = 2'h0;
    localparam logic [1:0] MFD_SEL_IFSR = 2'h1;
    localparam logic [1:0] MFD_SEL_FAR = 2'h2;
    localparam logic [1:0] MFD_SEL_DACR = 2'h3;
    localparam logic [7:0] MFD_FSR_RST = 8'h00;
    localparam logic [31:0] MFD_FAR_RST = 32'h0000_0000;
    localparam logic [31:0] MFD_DACR_RST = 32'h0000_0000;
    localparam int MFD_KB_LSB = 10;
    // ----------------------------------------
    // fault status codes
    // ----------------------------------------
    localparam logic [3:0] MFD_ST_ALIGN = 4'h1;
    localparam logic [3:0] MFD_ST_EXT_L1 = 4'hc;
    localparam logic [3:0] MFD_ST_EXT_L2 = 4'he;
    localparam logic [3:0] MFD_ST_TR_SEC = 4'h5;
    localparam logic [3:0] MFD_ST_TR_PAGE = 4'h7;
    localparam logic [3:0] MFD_ST_DOM_SEC = 4'h9;
    localparam logic [3:0] MFD_ST_DOM_PAGE = 4'hb;
    localparam logic [3:0] MFD_ST_PERM_SEC = 4'hd;
    localparam logic [3:0] MFD_ST_PERM_PAGE = 4'hf;
    localparam logic [3:0] MFD_ST_EXT = 4'h8;
    localparam logic [3:0] MFD_DOM_NONE = 4'h0;
    // ----------------------------------------
    // encodings
    // ----------------------------------------
    typedef enum logic [1:0] {MFD_L1_FAULT, MFD_L1_SECTION, MFD_L1_PAGE} mfd_l1_t;
    typedef enum logic [1:0] {MFD_L2_FAULT, MFD_L2_LARGE, MFD_L2_SMALL, MFD_L2_TINY} mfd_l2_t;
    typedef enum logic [1:0] {MFD_SZ_BYTE, MFD_SZ_HALF, MFD_SZ_WORD} mfd_size_t;
    typedef enum logic [1:0] {MFD_ACC_CACHED, MFD_ACC_NC_READ, MFD_ACC_NB_WRITE,
        MFD_ACC_SWAP} mfd_acc_t;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic mmu_en;
        logic align_en;
        logic sys_prot;
        logic rom_prot;
    } mfd_ctl_t;
    typedef struct packed {
        logic valid;
        logic [31:0] va;
        logic is_data;
        logic is_cache_op;
        logic is_write;
        logic is_priv;
        mfd_size_t size;
        logic first;
        logic last;
        mfd_l1_t l1;
        logic [3:0] l1_dom;
        logic [1:0] l1_ap;
        logic l1_ext;
        mfd_l2_t l2;
        logic [7:0] l2_ap;
        logic l2_ext;
    } mfd_req_t;
    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] va;
        logic is_data;
        mfd_acc_t acc;
        logic first;
        logic last;
    } mfd_resp_t;
    typedef struct packed {
        logic wr;
        logic [1:0] sel;
        logic [31:0] wdata;
    } mfd_cp_t;
    typedef struct packed {
        logic [7:0] dfsr;
        logic [7:0] ifsr;
        logic [31:0] fault_address;
        logic [31:0] dacr;
        logic abort;
        logic abort_data;
        logic bus_go;
        logic [31:0] bus_va;
        logic [31:0] rdata;
        logic far_lock;
        logic [21:0] base_hi;
        logic ext_pend;
        logic ext_any;
        logic ext_done;
        logic [31:0] prev_va;
    } mfd_state_t;
endpackage
`default_nettype wire

// ### mfd_perm.sv
/*
 * access permission decoder: resolves one two-bit permission field into allow/deny.
 * assumes the caller has already chosen the field and the protection bits.
 */
`timescale 1ns/1ps
`default_nettype none
module mfd_perm (
    input wire logic [1:0] i_ap,
    input wire logic i_sys_prot,
    input wire logic i_rom_prot,
    input wire logic i_priv,
    input wire logic i_write,
    output logic o_ok
);
    always_comb begin
        unique case (i_ap)
            2'h0: begin
                // both protection bits set is unpredictable; denied here for safety
                unique case ({i_sys_prot, i_rom_prot})
                    2'h2: o_ok = i_priv & ~i_write;
                    2'h1: o_ok = ~i_write;
                    default: o_ok = 1'b0;
                endcase
            end
            2'h1: o_ok = i_priv;
            2'h2: o_ok = i_priv | ~i_write;
            default: o_ok = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// ### mfd_checker.sv
/*
 * mmu fault detection: alignment, translation, domain, permission and external aborts,
 * with fault status, fault address and domain access control registers.
 * assumes descriptors are already fetched by the walker and that the core reaches the
 * registers through coprocessor transfers on i_cp; reads answer on o_cp_rdata next cycle.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - alignment checked only when enabled, data only
// - translation, domain, permission need translation enabled
// - external aborts only on uncached-type accesses
// - detected fault aborts access, signals core
// - faulting access never starts a bus transfer
// - status and domain into data/instruction register
// - data abort captures address into fault_address
// - prefetch faults leave fault_address unchanged
// - report highest of simultaneous abort sources
// - alignment status 0001, domain not valid
// - table fetch abort 1100 or 1110
// - codes for translation, domain, permission, external
// - domain may be invalid before descriptor read
// - prefetch cache operation updates instruction status
// - multi-word: first aborted word's address
// - external multi-word: address around 1KB boundary
// - sixteen two-bit domains in one register
// - domain 00 or 10 gives domain fault
// - client domain checks access permission bits
// - manager domain skips permission check
// - permission 00 uses system/rom protection bits
// - permission 01, 10, 11 fixed rights
// - quarter-page permission field, tiny uses one
module mfd_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire mfd_pkg::mfd_ctl_t i_ctl,
    input wire mfd_pkg::mfd_req_t i_req,
    input wire mfd_pkg::mfd_resp_t i_resp,
    input wire mfd_pkg::mfd_cp_t i_cp,
    output logic o_abort,
    output logic o_abort_data,
    output logic o_bus_go,
    output logic [31:0] o_bus_va,
    output logic [31:0] o_cp_rdata
);
    import mfd_pkg::*;

    mfd_state_t s_r;
    mfd_state_t s_nxt;

    // ----------------------------------------
    // fault detection
    // ----------------------------------------
    logic mis;
    logic align_f;
    logic mmu;
    logic l1ext_f;
    logic l2ext_f;
    logic trs_f;
    logic trp_f;
    logic dom_f;
    logic perm_f;
    logic perm_ok;
    logic req_fault;
    logic is_sec;
    logic [1:0] dfield;
    logic [1:0] q;
    logic [1:0] ap_sel;
    logic [3:0] code;
    logic [3:0] dom;

    always_comb begin
        unique case (i_req.size)
            MFD_SZ_HALF: mis = i_req.va[0];
            MFD_SZ_WORD: mis = |i_req.va[1:0];
            default: mis = 1'b0;
        endcase
    end

    assign align_f = i_ctl.align_en & i_req.is_data & mis;
    assign mmu = i_ctl.mmu_en;
    assign is_sec = (i_req.l1 == MFD_L1_SECTION);
    assign dfield = s_r.dacr[{i_req.l1_dom, 1'b0} +: 2];
    assign l1ext_f = mmu & i_req.l1_ext;
    assign l2ext_f = mmu & (i_req.l1 == MFD_L1_PAGE) & i_req.l2_ext;
    assign trs_f = mmu & (i_req.l1 == MFD_L1_FAULT);
    assign trp_f = mmu & (i_req.l1 == MFD_L1_PAGE) & (i_req.l2 == MFD_L2_FAULT);
    assign dom_f = mmu & (i_req.l1 != MFD_L1_FAULT) & ~dfield[0];
    // quarter of a large page is 16KB, of a small page 1KB
    assign q = (i_req.l2 == MFD_L2_LARGE) ? i_req.va[15:14] : i_req.va[11:10];
    assign ap_sel = is_sec ? i_req.l1_ap :
        (i_req.l2 == MFD_L2_TINY) ? i_req.l2_ap[1:0] : i_req.l2_ap[{q, 1'b0} +: 2];
    // only a client is checked; a manager never faults on permission
    assign perm_f = mmu & (i_req.l1 != MFD_L1_FAULT) & (dfield == 2'h1) & ~perm_ok;

    mfd_perm u_perm (
        .i_ap(ap_sel),
        .i_sys_prot(i_ctl.sys_prot),
        .i_rom_prot(i_ctl.rom_prot),
        .i_priv(i_req.is_priv),
        .i_write(i_req.is_write),
        .o_ok(perm_ok)
    );

    // ----------------------------------------
    // priority encoding
    // ----------------------------------------
    always_comb begin
        req_fault = 1'b1;
        dom = i_req.l1_dom;
        code = MFD_ST_EXT;
        if (align_f) begin
            code = MFD_ST_ALIGN;
            dom = MFD_DOM_NONE;
        end else if (l1ext_f) begin
            code = MFD_ST_EXT_L1;
            dom = MFD_DOM_NONE;
        end else if (l2ext_f) begin
            code = MFD_ST_EXT_L2;
        end else if (trs_f) begin
            code = MFD_ST_TR_SEC;
            dom = MFD_DOM_NONE;
        end else if (trp_f) begin
            code = MFD_ST_TR_PAGE;
        end else if (dom_f) begin
            code = is_sec ? MFD_ST_DOM_SEC : MFD_ST_DOM_PAGE;
        end else if (perm_f) begin
            code = is_sec ? MFD_ST_PERM_SEC : MFD_ST_PERM_PAGE;
        end else begin
            req_fault = 1'b0;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic ext_ok;
    logic after;
    logic [21:0] hi;

    // only accesses that hold the core in step with the bus may abort externally
    assign ext_ok = i_resp.valid & i_resp.err & (i_resp.acc != MFD_ACC_CACHED);
    assign hi = i_resp.first ? i_resp.va[31:MFD_KB_LSB] : s_r.base_hi;
    assign after = (i_resp.va[31:MFD_KB_LSB] != hi);

    always_comb begin
        s_nxt = s_r;
        s_nxt.abort = 1'b0;
        s_nxt.bus_go = 1'b0;
        // software writes first so hardware updates in the same cycle win
        if (i_cp.wr) begin
            unique case (i_cp.sel)
                MFD_SEL_DFSR: s_nxt.dfsr = i_cp.wdata[7:0];
                MFD_SEL_IFSR: s_nxt.ifsr = i_cp.wdata[7:0];
                MFD_SEL_FAR: s_nxt.fault_address = i_cp.wdata;
                default: s_nxt.dacr = i_cp.wdata;
            endcase
        end
        unique case (i_cp.sel)
            MFD_SEL_DFSR: s_nxt.rdata = {24'h00_0000, s_r.dfsr};
            MFD_SEL_IFSR: s_nxt.rdata = {24'h00_0000, s_r.ifsr};
            MFD_SEL_FAR: s_nxt.rdata = s_r.fault_address;
            default: s_nxt.rdata = s_r.dacr;
        endcase
        // bus answers belong to older accesses, so they are recorded first
        if (i_resp.valid) begin
            if (i_resp.first) begin
                s_nxt.base_hi = i_resp.va[31:MFD_KB_LSB];
                s_nxt.ext_pend = 1'b0;
                s_nxt.ext_any = 1'b0;
                s_nxt.ext_done = 1'b0;
            end
            if (ext_ok) begin
                s_nxt.abort = 1'b1;
                s_nxt.abort_data = i_resp.is_data;
                if (i_resp.is_data) begin
                    s_nxt.dfsr = {MFD_DOM_NONE, MFD_ST_EXT};
                end else begin
                    s_nxt.ifsr = {MFD_DOM_NONE, MFD_ST_EXT};
                end
            end
            if (i_resp.is_data) begin
                // crossing word: report the last word before the boundary
                if (after & s_nxt.ext_pend & ~s_nxt.ext_done) begin
                    s_nxt.fault_address = s_r.prev_va;
                    s_nxt.ext_done = 1'b1;
                end
                if (ext_ok) begin
                    s_nxt.ext_any = 1'b1;
                    s_nxt.ext_pend = s_nxt.ext_pend | ~after;
                end
                if (i_resp.last & s_nxt.ext_any & ~s_nxt.ext_done) begin
                    s_nxt.fault_address = i_resp.va;
                    s_nxt.ext_done = 1'b1;
                end
                s_nxt.prev_va = i_resp.va;
            end
        end
        if (i_req.valid) begin
            if (i_req.first) begin
                s_nxt.far_lock = 1'b0;
            end
            if (req_fault) begin
                s_nxt.abort = 1'b1;
                s_nxt.abort_data = i_req.is_data;
                if (i_req.is_data) begin
                    s_nxt.dfsr = {dom, code};
                    if (i_req.first | ~s_r.far_lock) begin
                        s_nxt.fault_address = i_req.va;
                    end
                    s_nxt.far_lock = ~i_req.last;
                end else begin
                    // fetches and prefetch cache operations share this path
                    s_nxt.ifsr = {dom, code};
                end
            end else begin
                s_nxt.bus_go = 1'b1;
                s_nxt.bus_va = i_req.va;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_r <= '0;
            s_r.dfsr <= MFD_FSR_RST;
            s_r.ifsr <= MFD_FSR_RST;
            s_r.fault_address <= MFD_FAR_RST;
            s_r.dacr <= MFD_DACR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_abort = s_r.abort;
    assign o_abort_data = s_r.abort_data;
    assign o_bus_go = s_r.bus_go;
    assign o_bus_va = s_r.bus_va;
    assign o_cp_rdata = s_r.rdata;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    property p_align_fetch;
        i_req.valid & ~i_req.is_data & ~i_ctl.mmu_en & ~i_resp.valid |=> !o_abort;
    endproperty
    a_align_fetch: assert property (p_align_fetch) else $error("fetch aborted");

    property p_mmu_off;
        i_req.valid & ~i_ctl.mmu_en & ~i_ctl.align_en & ~i_resp.valid
            |=> o_bus_go & !o_abort & (o_bus_va == $past(i_req.va));
    endproperty
    a_mmu_off: assert property (p_mmu_off) else $error("fault with mmu off");

    property p_ext_cached;
        i_resp.valid & (i_resp.acc == MFD_ACC_CACHED) & ~i_req.valid |=> !o_abort;
    endproperty
    a_ext_cached: assert property (p_ext_cached) else $error("cached access aborted");

    property p_fault_nogo;
        i_req.valid & req_fault |=> o_abort & !o_bus_go;
    endproperty
    a_fault_nogo: assert property (p_fault_nogo) else $error("faulting access on bus");

    property p_align_code;
        i_req.valid & align_f |=> (s_r.dfsr == {MFD_DOM_NONE, MFD_ST_ALIGN}) && o_abort_data;
    endproperty
    a_align_code: assert property (p_align_code) else $error("alignment status wrong");

    property p_far_fetch;
        i_req.valid & ~i_req.is_data & ~i_resp.valid & ~i_cp.wr |=> $stable(s_r.fault_address);
    endproperty
    a_far_fetch: assert property (p_far_fetch) else $error("fetch changed address");

    property p_far_data;
        i_req.valid & i_req.is_data & i_req.first & req_fault |=> s_r.fault_address == $past(i_req.va);
    endproperty
    a_far_data: assert property (p_far_data) else $error("fault address not captured");

    property p_manager;
        i_req.valid & i_ctl.mmu_en & is_sec & (dfield == 2'h3) & ~align_f & ~i_req.l1_ext
            |=> o_bus_go;
    endproperty
    a_manager: assert property (p_manager) else $error("manager access blocked");

    property p_dom_fault;
        i_req.valid & i_req.is_data & i_ctl.mmu_en & is_sec & ~dfield[0] & ~align_f
            & ~i_req.l1_ext |=> s_r.dfsr[3:0] == MFD_ST_DOM_SEC;
    endproperty
    a_dom_fault: assert property (p_dom_fault) else $error("domain fault missing");

    property p_ifsr;
        i_req.valid & ~i_req.is_data & i_req.is_cache_op & i_ctl.mmu_en
            & (i_req.l1 == MFD_L1_PAGE) & (i_req.l2 == MFD_L2_FAULT) & ~i_req.l1_ext
            & ~i_req.l2_ext |=> s_r.ifsr == {$past(i_req.l1_dom), MFD_ST_TR_PAGE};
    endproperty
    a_ifsr: assert property (p_ifsr) else $error("instruction status wrong");

    property p_l1ext_code;
        i_req.valid & i_req.is_data & i_ctl.mmu_en & i_req.l1_ext & ~align_f
            |=> s_r.dfsr == {MFD_DOM_NONE, MFD_ST_EXT_L1};
    endproperty
    a_l1ext_code: assert property (p_l1ext_code) else $error("table fetch status wrong");

    property p_perm_page;
        i_req.valid & i_req.is_data & i_ctl.mmu_en & (i_req.l1 == MFD_L1_PAGE)
            & (i_req.l2 != MFD_L2_FAULT) & (dfield == 2'h1) & ~perm_ok & ~align_f
            & ~i_req.l1_ext & ~i_req.l2_ext |=> s_r.dfsr[3:0] == MFD_ST_PERM_PAGE;
    endproperty
    a_perm_page: assert property (p_perm_page) else $error("page permission status wrong");

    property p_ext_abort;
        i_resp.valid & i_resp.err & (i_resp.acc != MFD_ACC_CACHED) |=> o_abort;
    endproperty
    a_ext_abort: assert property (p_ext_abort) else $error("bus error not reported");

    // aborts come only from a request or a bus answer
    property p_quiet;
        ~i_req.valid & ~i_resp.valid |=> !o_abort & !o_bus_go;
    endproperty
    a_quiet: assert property (p_quiet) else $error("abort without access");

    property p_dacr_read;
        i_cp.sel == MFD_SEL_DACR |=> o_cp_rdata == $past(s_r.dacr);
    endproperty
    a_dacr_read: assert property (p_dacr_read) else $error("domain register read wrong");

    property p_ext_far;
        i_resp.valid & i_resp.is_data & i_resp.first & i_resp.last & ext_ok & ~i_req.valid
            |=> s_r.fault_address == $past(i_resp.va);
    endproperty
    a_ext_far: assert property (p_ext_far) else $error("bus error address wrong");

    c_data_abort: cover property (i_req.valid & i_req.is_data & perm_f ##1 o_abort);
    c_bus_go: cover property (i_req.valid & ~req_fault ##1 o_bus_go);
    c_ext_abort: cover property (ext_ok ##1 o_abort);
    c_cross: cover property (i_resp.valid & after & s_r.ext_pend);
    c_fetch_abort: cover property (i_req.valid & ~i_req.is_data & req_fault ##1 o_abort);
endmodule
`default_nettype wire

// ### mfd_bus_model.sv
/*
 * bus partner: answers each transfer start with one response, in order.
 * assumes the bench picks error address, framing, access kind and pacing.
 */
`timescale 1ns/1ps
`default_nettype none
module mfd_bus_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [31:0] i_va,
    input wire logic [31:0] i_err_va,
    input wire logic [31:0] i_first_va,
    input wire logic [31:0] i_last_va,
    input wire mfd_pkg::mfd_acc_t i_acc,
    input wire logic i_slow,
    output var mfd_pkg::mfd_resp_t o_resp
);
    import mfd_pkg::*;
    logic [31:0] q[$];
    mfd_resp_t nx;
    int gap = 0;
    initial o_resp = '0;
    // ----------------------------------------
    // answer path
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_go) q.push_back(i_va);
        #1;
        // idle lines flip so a stale answer never looks good
        nx = ~o_resp;
        nx.valid = 1'b0;
        if (q.size() > 0 && gap == 0) begin
            nx.valid = 1'b1;
            nx.va = q.pop_front();
            // error only where the bench asks, cached kind included on purpose
            nx.err = (nx.va == i_err_va);
            nx.acc = i_acc;
            nx.is_data = 1'b1;
            nx.first = (nx.va == i_first_va);
            nx.last = (nx.va == i_last_va);
            gap = i_slow ? 3 : 0;
        end else if (gap > 0) gap--;
        o_resp = nx;
    end
endmodule
`default_nettype wire

// ### tb_mfd_checker.sv
/*
 * bench for mfd_checker: core requests and coprocessor transfers in, bus model behind.
 * assumes 100 MHz clock, synchronous reset and answers one cycle after each request.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_mfd_checker;
    import mfd_pkg::*;
    localparam logic [2:0] e_go = 3'h1, e_ad = 3'h6, e_ai = 3'h2;
    logic clk = 1'b0, srst = 1'b1, slow = 1'b0, ext_on = 1'b0;
    logic rd_go = 1'b0, p1 = 1'b0, rp = 1'b0;
    logic abort, abort_data, bus_go;
    logic [31:0] bus_va, cp_rdata, err_va = '1, first_va = '1, last_va = '1;
    logic [31:0] lf = 32'h0000_0042;
    logic [31:0] exq[$], vaq[$];
    mfd_ctl_t ctl = '0;
    mfd_req_t req = '0, r = '0;
    mfd_resp_t resp;
    mfd_cp_t cp = '0;
    mfd_acc_t acc = MFD_ACC_NC_READ;
    int n_fail = 0, checked = 0;
    initial forever #5 clk = ~clk;
    mfd_checker u_mfd_checker (.i_clk(clk), .i_srst(srst), .i_ctl(ctl), .i_req(req),
        .i_resp(resp), .i_cp(cp), .o_abort(abort), .o_abort_data(abort_data),
        .o_bus_go(bus_go), .o_bus_va(bus_va), .o_cp_rdata(cp_rdata));
    mfd_bus_model u_mfd_bus_model (.i_clk(clk), .i_go(bus_go), .i_va(bus_va),
        .i_err_va(err_va), .i_first_va(first_va), .i_last_va(last_va), .i_acc(acc),
        .i_slow(slow), .o_resp(resp));
    // ----------------------------------------
    // stimulus tasks
    // ----------------------------------------
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction
    function automatic logic ok(input logic [1:0] ap, input logic s, input logic rr,
        input logic p, input logic w);
        case (ap)
            2'h0: return !w && ((s && !rr && p) || (rr && !s));
            2'h1: return p;
            2'h2: return p || !w;
            default: return 1'b1;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cpw(input logic [1:0] s, input logic [31:0] d);
        step(1);
        cp = '{wr: 1'b1, sel: s, wdata: d};
        step(1);
        cp.wr = 1'b0;
    endtask
    task automatic cpr(input logic [1:0] s, input logic [31:0] e);
        step(1);
        cp.sel = s;
        rd_go = 1'b1;
        exq.push_back(e);
        step(1);
        rd_go = 1'b0;
    endtask
    task automatic base;
        r = '0;
        r.valid = 1'b1;
        r.is_data = 1'b1;
        r.is_priv = 1'b1;
        r.size = MFD_SZ_WORD;
        r.first = 1'b1;
        r.last = 1'b1;
        r.l1 = MFD_L1_SECTION;
        r.l1_ap = 2'h3;
        r.l2 = MFD_L2_SMALL;
    endtask
    task automatic send(input logic [2:0] e);
        step(1);
        req = r;
        exq.push_back(32'(e));
        vaq.push_back(r.va);
    endtask
    task automatic idle;
        step(1);
        req.valid = 1'b0;
        step(3);
    endtask
    task automatic one(input logic [2:0] e);
        send(e);
        idle();
    endtask
    // words back to back, one of them refused by the bus
    task automatic burst(input logic [31:0] a, input int n, input logic [31:0] ev,
        input logic [31:0] ef);
        err_va = ev;
        first_va = a;
        last_va = a + 32'(4 * (n - 1));
        base();
        for (int k = 0; k < n; k++) begin
            r.va = a + 32'(4 * k);
            r.first = (k == 0);
            r.last = (k == n - 1);
            send(e_go);
        end
        idle();
        step(4);
        cpr(2'h2, ef);
    endtask
    // ----------------------------------------
    // result watch
    // ----------------------------------------
    always @(posedge clk) begin
        p1 <= req.valid;
        rp <= rd_go;
    end
    // answers stand for the one cycle after the request edge
    always @(negedge clk) begin
        logic [31:0] e;
        logic [31:0] v;
        if (p1 || rp) begin
            e = exq.pop_front();
            if (rp) chk(cp_rdata, e);
            else begin
                v = vaq.pop_front();
                chk(32'(bus_go), 32'(e[0]));
                if (e[0]) chk(bus_va, v);
                if (!ext_on) chk(32'(abort), 32'(e[1]));
                if (!ext_on && e[1]) chk(32'(abort_data), 32'(e[2]));
            end
        end
    end
    initial begin
        step(20000);
        n_fail++;
        results();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        step(2);
        srst = 1'b0;
        for (int i = 0; i < 4; i++) cpr(2'(i), 32'h0);
        lf = nx(lf);
        cpw(2'h3, lf);
        cpr(2'h3, lf);
        cpw(2'h3, 32'h0000_0087);
        // translation off: only the alignment check may fire
        ctl.align_en = 1'b1;
        base();
        r.va = 32'h0000_1002;
        r.l1 = MFD_L1_FAULT;
        one(e_ad);
        cpr(2'h0, 32'h01);
        cpr(2'h2, 32'h1002);
        r.size = MFD_SZ_HALF;
        r.va = 32'h0000_1001;
        one(e_ad);
        r.size = MFD_SZ_BYTE;
        one(e_go);
        r.size = MFD_SZ_WORD;
        r.is_data = 1'b0;
        one(e_go);
        r.is_data = 1'b1;
        ctl = '{mmu_en: 1'b1, align_en: 1'b1, sys_prot: 1'b0, rom_prot: 1'b0};
        r.l1_ext = 1'b1;
        r.l1_dom = 4'h5;
        one(e_ad);
        cpr(2'h0, 32'h01);
        r.va = 32'h0000_2000;
        one(e_ad);
        cpr(2'h0, 32'h0c);
        r.l1_ext = 1'b0;
        one(e_ad);
        cpr(2'h0, 32'h05);
        r.l1 = MFD_L1_PAGE;
        r.l2 = MFD_L2_FAULT;
        r.l2_ext = 1'b1;
        one(e_ad);
        cpr(2'h0, 32'h5e);
        r.l2_ext = 1'b0;
        one(e_ad);
        cpr(2'h0, 32'h57);
        r.l2 = MFD_L2_SMALL;
        one(e_ad);
        cpr(2'h0, 32'h5b);
        r.l1 = MFD_L1_SECTION;
        r.l1_dom = 4'h3;
        one(e_ad);
        cpr(2'h0, 32'h39);
        for (int i = 0; i < 64; i++) begin
            lf = nx(lf);
            base();
            r.va = {lf[31:2], 2'b00};
            r.l1_dom = 4'h1;
            r.l1_ap = i[1:0];
            r.is_priv = i[2];
            r.is_write = i[3];
            ctl.sys_prot = i[4];
            ctl.rom_prot = i[5];
            one(ok(i[1:0], i[4], i[5], i[2], i[3]) ? e_go : e_ad);
        end
        ctl.sys_prot = 1'b0;
        ctl.rom_prot = 1'b0;
        r.l1_ap = 2'h0;
        one(e_ad);
        cpr(2'h0, 32'h1d);
        r.l1_dom = 4'h0;
        one(e_go);
        r.l1_dom = 4'h1;
        r.l1 = MFD_L1_PAGE;
        r.l2_ap = 8'hc0;
        for (int t = 0; t < 2; t++) begin
            r.l2 = t ? MFD_L2_LARGE : MFD_L2_SMALL;
            r.va = 32'h3 << (t ? 14 : 10);
            one(e_go);
            r.va = 32'h1 << (t ? 14 : 10);
            one(e_ad);
        end
        cpr(2'h0, 32'h1f);
        r.l2 = MFD_L2_TINY;
        r.l2_ap = 8'h03;
        one(e_go);
        lf = nx(lf);
        cpw(2'h2, lf);
        base();
        r.is_data = 1'b0;
        r.l1 = MFD_L1_FAULT;
        one(e_ai);
        cpr(2'h1, 32'h05);
        cpr(2'h2, lf);
        r.is_cache_op = 1'b1;
        r.l1 = MFD_L1_PAGE;
        r.l1_dom = 4'h4;
        r.l2 = MFD_L2_FAULT;
        one(e_ai);
        cpr(2'h1, 32'h47);
        base();
        r.last = 1'b0;
        r.va = 32'h0000_0100;
        send(e_go);
        r.first = 1'b0;
        r.va = 32'h0000_0106;
        send(e_ad);
        r.last = 1'b1;
        r.va = 32'h0000_010a;
        send(e_ad);
        idle();
        cpr(2'h2, 32'h0000_0106);
        // bus errors: aborts are judged through the registers only
        ext_on = 1'b1;
        slow = 1'b1;
        for (int a = 0; a < 4; a++) begin
            acc = mfd_acc_t'(a);
            cpw(2'h0, 32'h0);
            cpw(2'h2, 32'h0);
            burst(32'h200, 1, 32'h200, a ? 32'h200 : 32'h0);
            cpr(2'h0, a ? 32'h08 : 32'h0);
        end
        slow = 1'b0;
        acc = MFD_ACC_NB_WRITE;
        burst(32'h3f8, 4, 32'h3fc, 32'h3fc);
        burst(32'h7f8, 5, 32'h804, 32'h808);
        results();
    end
endmodule
`default_nettype wire
